// File: hw/timer16_pwm.sv
// 16-bit timer waveform generator: fast PWM and phase correct PWM behind an APB slave
`timescale 1ns/100ps
`default_nettype none

module timer16_pwm (
  input  wire logic                       clk,
  input  wire logic                       srst,
  input  wire logic [pwm16_pkg::ADDR_W-1:0] paddr,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  output logic                            pin_a_o,
  output logic                            pin_a_oe,
  output logic                            pin_b_o,
  output logic                            pin_b_oe
);
  import pwm16_pkg::*;

  // ************************************************************
  // State
  // ************************************************************
  ctrl_s             ctrl_ff;
  logic [15:0]       cnt_ff;
  logic [15:0]       buf_a_ff;
  logic [15:0]       buf_b_ff;
  logic [15:0]       act_a_ff;
  logic [15:0]       act_b_ff;
  logic [15:0]       capt_ff;
  logic [FLG_W-1:0]  flags_ff;
  dir_e              dir_ff;
  logic              wave_a_ff;
  logic              wave_b_ff;
  logic [PS_W-1:0]   presc_ff;
  logic [31:0]       prdata_ff;
  logic              pready_ff;
  logic              pslverr_ff;
  logic              pin_a_o_ff;
  logic              pin_a_oe_ff;
  logic              pin_b_o_ff;
  logic              pin_b_oe_ff;

  logic [15:0]       nxt_cnt;
  dir_e              nxt_dir;
  logic              nxt_wave_a;
  logic              nxt_wave_b;

  // ************************************************************
  // APB decode
  // ************************************************************
  wire        setup      = psel & ~penable;
  wire        wr_en      = psel & penable & pready_ff & pwrite;
  wire        hit_ctrl   = (paddr == OFF_CTRL);
  wire        hit_count  = (paddr == OFF_COUNT);
  wire        hit_cmp_a  = (paddr == OFF_CMP_A);
  wire        hit_cmp_b  = (paddr == OFF_CMP_B);
  wire        hit_capt   = (paddr == OFF_CAPT);
  wire        hit_flags  = (paddr == OFF_FLAGS);
  wire        hit_status = (paddr == OFF_STATUS);
  wire        mapped     = hit_ctrl | hit_count | hit_cmp_a | hit_cmp_b
                         | hit_capt | hit_flags | hit_status;
  wire        cnt_wr     = wr_en & hit_count;
  wire        cmp_a_wr   = wr_en & hit_cmp_a;
  wire        cmp_b_wr   = wr_en & hit_cmp_b;
  wire [31:0] status_w   = {29'h0000000, wave_b_ff, wave_a_ff, dir_ff == DIR_DOWN};
  // Read mux; unmapped addresses read zero and flag an error
  wire [31:0] rd_data    = hit_ctrl   ? {19'h00000, ctrl_ff}
                         : hit_count  ? {16'h0000, cnt_ff}
                         : hit_cmp_a  ? {16'h0000, buf_a_ff}
                         : hit_cmp_b  ? {16'h0000, buf_b_ff}
                         : hit_capt   ? {16'h0000, capt_ff}
                         : hit_flags  ? {28'h0000000, flags_ff}
                         : hit_status ? status_w
                         : 32'h00000000;

  // ************************************************************
  // Mode and TOP selection
  // ************************************************************
  wire [3:0]  mode      = ctrl_ff.waveform_mode_select;
  wire        fix8      = (mode == MODE_PC8)  | (mode == MODE_FP8);
  wire        fix9      = (mode == MODE_PC9)  | (mode == MODE_FP9);
  wire        fix10     = (mode == MODE_PC10) | (mode == MODE_FP10);
  wire        top_capt  = (mode == MODE_PC_CAPT)  | (mode == MODE_FP_CAPT);
  wire        top_cmp_a = (mode == MODE_PC_CMP_A) | (mode == MODE_FP_CMP_A);
  wire        fast      = (mode == MODE_FP8) | (mode == MODE_FP9) | (mode == MODE_FP10)
                        | (mode == MODE_FP_CAPT) | (mode == MODE_FP_CMP_A);
  wire        pc        = (mode == MODE_PC8) | (mode == MODE_PC9) | (mode == MODE_PC10)
                        | (mode == MODE_PC_CAPT) | (mode == MODE_PC_CMP_A);
  wire        pwm       = fast | pc;
  // TOP source per mode
  wire [15:0] top_val   = fix8 ? TOP_8BIT : fix9 ? TOP_9BIT : fix10 ? TOP_10BIT
                        : top_capt ? capt_ff : top_cmp_a ? act_a_ff : 16'hffff;
  // Fixed TOP masks unused compare bits on write
  wire [15:0] wr_mask   = (fix8 | fix9 | fix10) ? top_val : 16'hffff;
  wire [15:0] wr_cmp    = pwdata[15:0] & wr_mask;

  // ************************************************************
  // Prescaler: timer tick as a clock enable
  // ************************************************************
  // Free-running divider; a tick is the cycle its low bits are all ones
  wire [2:0]  cs        = ctrl_ff.clock_select;
  wire        tick      = (cs == CS_DIV1)
                        | ((cs == CS_DIV8)    & ((presc_ff & PS_MASK_8)    == PS_MASK_8))
                        | ((cs == CS_DIV64)   & ((presc_ff & PS_MASK_64)   == PS_MASK_64))
                        | ((cs == CS_DIV256)  & ((presc_ff & PS_MASK_256)  == PS_MASK_256))
                        | ((cs == CS_DIV1024) & ((presc_ff & PS_MASK_1024) == PS_MASK_1024));

  // ************************************************************
  // Counter events
  // ************************************************************
  wire        at_top    = (cnt_ff == top_val);
  wire        at_bottom = (cnt_ff == BOTTOM);
  wire        match_a   = (cnt_ff == act_a_ff);
  wire        match_b   = (cnt_ff == act_b_ff);
  wire        going_up  = (dir_ff == DIR_UP);
  // BOTTOM turnaround counts as rising, TOP turnaround as falling
  wire        rising    = (going_up & ~at_top) | (~going_up & at_bottom);
  wire        top_evt   = tick & at_top & (fast | (pc & going_up));
  wire        ovf_set   = tick & ((fast & at_top) | (pc & ~going_up & at_bottom));
  wire [3:0]  flag_set;
  wire [3:0]  flag_clr  = (wr_en & hit_flags) ? pwdata[3:0] : 4'h0;
  wire        toggle_ok = top_cmp_a;

  assign flag_set[FLG_OVF]     = ovf_set;
  assign flag_set[FLG_MATCH_A] = tick & pwm & match_a;
  assign flag_set[FLG_MATCH_B] = tick & pwm & match_b;
  assign flag_set[FLG_CAPT]    = top_evt & top_capt;

  // Next output level for one channel on a timer tick
  function automatic logic wave_next(input logic cur, input logic [1:0] act,
                                     input logic tgl_ok, input logic match);
    logic res;
    res = cur;
    if (act == ACT_TOGGLE) begin
      res = (tgl_ok & match) ? ~cur : cur;
    end else if (act != ACT_OFF) begin
      if (fast) begin
        // Wrap wins over a match at TOP, so a TOP compare stays constant
        res = at_top ? (act == ACT_NONINV) : match ? (act == ACT_INV) : cur;
      end else if (match) begin
        res = rising ? (act == ACT_INV) : (act == ACT_NONINV);
      end
    end
    return res;
  endfunction

  // Counter and direction next state
  always_comb begin
    nxt_cnt    = cnt_ff;
    nxt_dir    = pc ? dir_ff : DIR_UP;
    nxt_wave_a = wave_a_ff;
    nxt_wave_b = wave_b_ff;
    if (tick & pwm) begin
      nxt_wave_a = wave_next(wave_a_ff, ctrl_ff.output_action_select_a, toggle_ok, match_a);
      nxt_wave_b = wave_next(wave_b_ff, ctrl_ff.output_action_select_b, 1'b0, match_b);
      if (fast) begin
        nxt_cnt = at_top ? BOTTOM : cnt_ff + 16'h0001;
      end else if (going_up) begin
        nxt_cnt = at_top ? cnt_ff - 16'h0001 : cnt_ff + 16'h0001;
        nxt_dir = at_top ? DIR_DOWN : DIR_UP;
      end else begin
        nxt_cnt = at_bottom ? cnt_ff + 16'h0001 : cnt_ff - 16'h0001;
        nxt_dir = at_bottom ? DIR_UP : DIR_DOWN;
      end
    end
    // Software write to the counter beats the tick
    if (cnt_wr) begin
      nxt_cnt = pwdata[15:0];
    end
  end

  // ************************************************************
  // Registers
  // ************************************************************
  // Software-facing configuration and counter
  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_ff  <= CTRL_RST;
      capt_ff  <= CAPT_RST;
      cnt_ff   <= CNT_RST;
      dir_ff   <= DIR_UP;
      presc_ff <= '0;
      flags_ff <= FLG_RST;
    end else begin
      if (wr_en & hit_ctrl) ctrl_ff <= pwdata[CTRL_W-1:0];
      if (wr_en & hit_capt) capt_ff <= pwdata[15:0];
      cnt_ff   <= nxt_cnt;
      dir_ff   <= nxt_dir;
      presc_ff <= presc_ff + 10'h001;
      flags_ff <= (flags_ff & ~flag_clr) | flag_set;   // Set wins over a clear
    end
  end

  // Double-buffered compares; outside PWM the buffer writes through
  always_ff @(posedge clk) begin
    if (srst) begin
      buf_a_ff <= CMP_RST;
      buf_b_ff <= CMP_RST;
      act_a_ff <= CMP_RST;
      act_b_ff <= CMP_RST;
    end else begin
      if (cmp_a_wr) buf_a_ff <= wr_cmp;
      if (cmp_b_wr) buf_b_ff <= wr_cmp;
      if (top_evt | ~pwm) begin
        act_a_ff <= buf_a_ff;
        act_b_ff <= buf_b_ff;
      end
    end
  end

  // Waveforms, pin drivers and APB answer; pins driven when direction bit set and action not off
  always_ff @(posedge clk) begin
    if (srst) begin
      wave_a_ff   <= 1'b0;
      wave_b_ff   <= 1'b0;
      pin_a_o_ff  <= 1'b0;
      pin_a_oe_ff <= 1'b0;
      pin_b_o_ff  <= 1'b0;
      pin_b_oe_ff <= 1'b0;
      prdata_ff   <= 32'h00000000;
      pready_ff   <= 1'b0;
      pslverr_ff  <= 1'b0;
    end else begin
      wave_a_ff   <= nxt_wave_a;
      wave_b_ff   <= nxt_wave_b;
      pin_a_o_ff  <= wave_a_ff;
      pin_a_oe_ff <= ctrl_ff.pin_direction_bit_a & (ctrl_ff.output_action_select_a != ACT_OFF);
      pin_b_o_ff  <= wave_b_ff;
      pin_b_oe_ff <= ctrl_ff.pin_direction_bit_b & (ctrl_ff.output_action_select_b != ACT_OFF);
      prdata_ff   <= setup ? rd_data : prdata_ff;   // Snapshot taken in the setup cycle
      pready_ff   <= setup;
      pslverr_ff  <= setup & ~mapped;
    end
  end

  assign prdata   = prdata_ff;
  assign pready   = pready_ff;
  assign pslverr  = pslverr_ff;
  assign pin_a_o  = pin_a_o_ff;
  assign pin_a_oe = pin_a_oe_ff;
  assign pin_b_o  = pin_b_o_ff;
  assign pin_b_oe = pin_b_oe_ff;

  // ************************************************************
  // Assertions
  // ************************************************************
  property p_hold_no_tick;
    @(posedge clk) disable iff (srst) (!tick && !cnt_wr) |=> $stable(cnt_ff);
  endproperty
  a_hold_no_tick: assert property (p_hold_no_tick) else $error("counter moved without tick");

  property p_fast_load;
    @(posedge clk) disable iff (srst) (fast && tick && at_top) |=> (act_a_ff == $past(buf_a_ff));
  endproperty
  a_fast_load: assert property (p_fast_load) else $error("compare A not loaded at TOP");

  property p_fast_wrap;
    @(posedge clk) disable iff (srst)
      (fast && tick && at_top && !cnt_wr) |=> (cnt_ff == BOTTOM) && flags_ff[FLG_OVF];
  endproperty
  a_fast_wrap: assert property (p_fast_wrap) else $error("no wrap or overflow at TOP");

  property p_pc_turn;
    @(posedge clk) disable iff (srst)
      (pc && tick && going_up && at_top && !cnt_wr)
        |=> (dir_ff == DIR_DOWN) && (cnt_ff == $past(cnt_ff) - 16'h0001);
  endproperty
  a_pc_turn: assert property (p_pc_turn) else $error("bad turnaround at TOP");

  property p_pc_ovf;
    @(posedge clk) disable iff (srst)
      (pc && tick && !going_up && at_bottom) |=> flags_ff[FLG_OVF] && (dir_ff == DIR_UP);
  endproperty
  a_pc_ovf: assert property (p_pc_ovf) else $error("overflow missing at BOTTOM");

  property p_match_flag;
    @(posedge clk) disable iff (srst) (pwm && tick && match_a) |=> flags_ff[FLG_MATCH_A];
  endproperty
  a_match_flag: assert property (p_match_flag) else $error("match flag A not set");

  property p_pin_off;
    @(posedge clk) disable iff (srst) !ctrl_ff.pin_direction_bit_a |=> !pin_a_oe;
  endproperty
  a_pin_off: assert property (p_pin_off) else $error("pin A driven while input");

  property p_pc_clear_up;
    @(posedge clk) disable iff (srst)
      (pc && tick && match_a && rising && ctrl_ff.output_action_select_a == ACT_NONINV)
        |=> ##1 !pin_a_o;
  endproperty
  a_pc_clear_up: assert property (p_pc_clear_up) else $error("up match did not clear A");

  property p_fast_inv_wrap;
    @(posedge clk) disable iff (srst)
      (fast && tick && at_top && ctrl_ff.output_action_select_a == ACT_INV) |=> !wave_a_ff;
  endproperty
  a_fast_inv_wrap: assert property (p_fast_inv_wrap) else $error("inverted wrap level");

  property p_mask;
    @(posedge clk) disable iff (srst) (cmp_a_wr && fix8) |=> (buf_a_ff[15:8] == 8'h00);
  endproperty
  a_mask: assert property (p_mask) else $error("compare bits above TOP kept");

  property p_fast_set_wrap;
    @(posedge clk) disable iff (srst)
      (fast && tick && at_top && ctrl_ff.output_action_select_a == ACT_NONINV) |=> wave_a_ff;
  endproperty
  a_fast_set_wrap: assert property (p_fast_set_wrap) else $error("wrap did not set A");

  // A match on the falling slope, TOP included, sets a non-inverted output
  property p_pc_set_down;
    @(posedge clk) disable iff (srst)
      (pc && tick && match_a && !rising && ctrl_ff.output_action_select_a == ACT_NONINV)
        |=> wave_a_ff;
  endproperty
  a_pc_set_down: assert property (p_pc_set_down) else $error("no set on down match");

  property p_toggle;
    @(posedge clk) disable iff (srst)
      (top_cmp_a && tick && match_a && ctrl_ff.output_action_select_a == ACT_TOGGLE)
        |=> (wave_a_ff != $past(wave_a_ff));
  endproperty
  a_toggle: assert property (p_toggle) else $error("output A did not toggle");

  property p_pc_load;
    @(posedge clk) disable iff (srst)
      (pc && tick && going_up && at_top) |=> (act_a_ff == $past(buf_a_ff));
  endproperty
  a_pc_load: assert property (p_pc_load) else $error("compare A not loaded at TOP");

  property p_capt_flag;
    @(posedge clk) disable iff (srst)
      (top_capt && tick && at_top && (fast || going_up)) |=> flags_ff[FLG_CAPT];
  endproperty
  a_capt_flag: assert property (p_capt_flag) else $error("capture flag not set at TOP");

  // Checked against the fixed constant, not the selected TOP, so a bad select shows
  property p_fixed_top;
    @(posedge clk) disable iff (srst)
      (pc && fix10 && tick && going_up && (cnt_ff == TOP_10BIT) && !cnt_wr)
        |=> (dir_ff == DIR_DOWN) && (cnt_ff == TOP_10BIT - 16'h0001);
  endproperty
  a_fixed_top: assert property (p_fixed_top) else $error("no turn at fixed TOP");

  property p_idle;
    @(posedge clk) disable iff (srst) (!pwm && !cnt_wr) |=> $stable(cnt_ff);
  endproperty
  a_idle: assert property (p_idle) else $error("counter moved outside PWM modes");

endmodule

`default_nettype wire

// File: hw/pwm16_pkg.sv
// Shared constants, field layouts and types of the 16-bit PWM waveform generator
package pwm16_pkg;

  // ************************************************************
  // Register map (byte addresses on APB)
  // ************************************************************
  localparam int          ADDR_W     = 8;
  localparam logic [7:0]  OFF_CTRL   = 8'h00;
  localparam logic [7:0]  OFF_COUNT  = 8'h04;
  localparam logic [7:0]  OFF_CMP_A  = 8'h08;
  localparam logic [7:0]  OFF_CMP_B  = 8'h0c;
  localparam logic [7:0]  OFF_CAPT   = 8'h10;
  localparam logic [7:0]  OFF_FLAGS  = 8'h14;
  localparam logic [7:0]  OFF_STATUS = 8'h18;

  // ************************************************************
  // Field layouts and reset values
  // ************************************************************
  typedef struct packed {
    logic       pin_direction_bit_b;
    logic       pin_direction_bit_a;
    logic [2:0] clock_select;
    logic [1:0] output_action_select_b;
    logic [1:0] output_action_select_a;
    logic [3:0] waveform_mode_select;
  } ctrl_s;
  localparam int          CTRL_W     = 13;
  localparam logic [12:0] CTRL_RST   = 13'h0000;
  localparam logic [15:0] CNT_RST    = 16'h0000;
  localparam logic [15:0] CMP_RST    = 16'h0000;
  localparam logic [15:0] CAPT_RST   = 16'h0000;
  localparam int          FLG_W      = 4;
  localparam logic [3:0]  FLG_RST    = 4'h0;
  localparam int          FLG_OVF    = 0;
  localparam int          FLG_MATCH_A = 1;
  localparam int          FLG_MATCH_B = 2;
  localparam int          FLG_CAPT   = 3;
  localparam int          ST_DOWN    = 0;
  localparam int          ST_WAVE_A  = 1;
  localparam int          ST_WAVE_B  = 2;

  // ************************************************************
  // Modes, actions, TOP values and prescaler
  // ************************************************************
  localparam logic [3:0]  MODE_PC8      = 4'h1;
  localparam logic [3:0]  MODE_PC9      = 4'h2;
  localparam logic [3:0]  MODE_PC10     = 4'h3;
  localparam logic [3:0]  MODE_FP8      = 4'h5;
  localparam logic [3:0]  MODE_FP9      = 4'h6;
  localparam logic [3:0]  MODE_FP10     = 4'h7;
  localparam logic [3:0]  MODE_PC_CAPT  = 4'ha;
  localparam logic [3:0]  MODE_PC_CMP_A = 4'hb;
  localparam logic [3:0]  MODE_FP_CAPT  = 4'he;
  localparam logic [3:0]  MODE_FP_CMP_A = 4'hf;
  localparam logic [1:0]  ACT_OFF       = 2'h0;
  localparam logic [1:0]  ACT_TOGGLE    = 2'h1;
  localparam logic [1:0]  ACT_NONINV    = 2'h2;
  localparam logic [1:0]  ACT_INV       = 2'h3;
  localparam logic [15:0] TOP_8BIT      = 16'h00ff;
  localparam logic [15:0] TOP_9BIT      = 16'h01ff;
  localparam logic [15:0] TOP_10BIT     = 16'h03ff;
  localparam logic [15:0] BOTTOM        = 16'h0000;
  localparam int          PS_W          = 10;
  localparam logic [2:0]  CS_DIV1       = 3'h1;
  localparam logic [2:0]  CS_DIV8       = 3'h2;
  localparam logic [2:0]  CS_DIV64      = 3'h3;
  localparam logic [2:0]  CS_DIV256     = 3'h4;
  localparam logic [2:0]  CS_DIV1024    = 3'h5;
  localparam logic [9:0]  PS_MASK_8     = 10'h007;
  localparam logic [9:0]  PS_MASK_64    = 10'h03f;
  localparam logic [9:0]  PS_MASK_256   = 10'h0ff;
  localparam logic [9:0]  PS_MASK_1024  = 10'h3ff;

  typedef enum logic {DIR_UP = 1'b0, DIR_DOWN = 1'b1} dir_e;

endpackage

// File: testbench/tb.sv
// Self-checking testbench of the 16-bit fast and phase correct PWM generator
`timescale 1ns/100ps
`default_nettype none
module tb;
  import pwm16_pkg::*;
  // ************************************************************
  // Signals, design instance, clock and watchdog
  // ************************************************************
  logic        clk, srst, psel, penable, pwrite, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, pin_a_o, pin_a_oe, pin_b_o, pin_b_oe;
  int          fails, num_checks, cycles;

  timer16_pwm i_timer16_pwm (.clk(clk), .srst(srst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pin_a_o(pin_a_o), .pin_a_oe(pin_a_oe), .pin_b_o(pin_b_o),
    .pin_b_oe(pin_b_oe));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Whole run is about 8000 cycles; the ceiling leaves ample margin
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      fails++;
      report_and_stop();
    end
  end

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic report_and_stop();
    if (fails == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  // One APB transfer; request held until pready is sampled high, only the watchdog ends a wait
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e,
                      input logic [31:0] m = 32'hffffffff);
    apb(1'b0, a, 32'h0);
    chk(n, e, rd & m);
  endtask

  task automatic do_reset();
    srst <= 1'b1;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
  endtask

  // Counting high samples over whole periods makes the result phase independent
  task automatic measure(input int n, output int h, input logic b = 1'b0);
    h = 0;
    repeat (n) begin
      @(posedge clk);
      h += int'((b ? pin_b_o : pin_a_o) === 1'b1);
    end
  endtask

  function automatic logic [31:0] ctrl(logic [3:0] m, logic [1:0] act, logic [2:0] cs,
                                       logic dir);
    ctrl_s c;
    c = '0;
    c.waveform_mode_select   = m;
    c.output_action_select_a = act;
    c.clock_select           = cs;
    c.pin_direction_bit_a    = dir;
    return {19'h0, c};
  endfunction

  // Counter idle while the compare is written, so it goes straight through to the active one
  task automatic start(input logic [3:0] m, input logic [15:0] top, input logic [15:0] cmp,
                       input logic [1:0] act, input logic [2:0] cs);
    do_reset();
    apb(1'b1, OFF_CAPT, {16'h0, top});
    apb(1'b1, OFF_CMP_A, {16'h0, cmp});
    apb(1'b1, OFF_CTRL, ctrl(m, act, cs, 1'b1));
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_regs();
    do_reset();
    rchk("ctrl_reset", OFF_CTRL, 32'h0);
    apb(1'b1, OFF_CAPT, 32'h0000abcd);
    rchk("capt_rw", OFF_CAPT, 32'h0000abcd);
    apb(1'b0, 8'h1c, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, err});
    apb(1'b1, OFF_CTRL, ctrl(MODE_FP8, ACT_NONINV, 3'h0, 1'b0));
    apb(1'b1, OFF_CMP_B, 32'h0000ffff);
    rchk("mask_8bit", OFF_CMP_B, 32'h000000ff);
    apb(1'b1, OFF_CTRL, ctrl(MODE_PC10, ACT_NONINV, 3'h0, 1'b0));
    apb(1'b1, OFF_CMP_A, 32'h0000ffff);
    rchk("mask_10bit", OFF_CMP_A, 32'h000003ff);
  endtask

  // Compare 5 written while running at count 2: old 12 must stay active until TOP
  task automatic t_buffer();
    int h;
    start(MODE_FP_CAPT, 16'h000f, 16'h000c, ACT_INV, CS_DIV1);
    apb(1'b1, OFF_CMP_A, 32'h00000005);
    repeat (6) @(posedge clk);
    chk("buffered_old_cmp", 32'h0, {31'h0, pin_a_o});
    repeat (20) @(posedge clk);
    measure(64, h);
    chk("buffered_new_cmp", 32'd40, h);
  endtask

  task automatic t_wave();
    logic [3:0]  md [11] = '{MODE_FP_CAPT, MODE_FP_CAPT, MODE_FP_CAPT, MODE_FP_CAPT,
      MODE_FP_CMP_A, MODE_PC_CAPT, MODE_PC_CAPT, MODE_PC_CAPT, MODE_PC_CAPT, MODE_PC_CAPT,
      MODE_PC_CMP_A};
    logic [1:0]  ac [11] = '{ACT_NONINV, ACT_INV, ACT_NONINV, ACT_NONINV, ACT_TOGGLE,
      ACT_NONINV, ACT_INV, ACT_NONINV, ACT_NONINV, ACT_INV, ACT_TOGGLE};
    logic [15:0] tp [11] = '{15, 15, 15, 15, 0, 16, 16, 16, 16, 16, 0};
    logic [15:0] cp [11] = '{5, 5, 0, 15, 7, 5, 5, 0, 16, 0, 8};
    int          ex [11] = '{24, 40, 4, 64, 32, 20, 44, 0, 64, 64, 32};
    int          h;
    for (int i = 0; i < 11; i++) begin
      start(md[i], tp[i], cp[i], ac[i], CS_DIV1);
      repeat (40) @(posedge clk);
      measure(64, h);
      chk("duty", ex[i], h);
      chk("drive_en", 32'h1, {31'h0, pin_a_oe});
    end
    apb(1'b1, OFF_CTRL, ctrl(MODE_PC_CMP_A, ACT_TOGGLE, CS_DIV1, 1'b0));
    repeat (3) @(posedge clk);
    chk("drive_off", 32'h0, {31'h0, pin_a_oe});
  endtask

  task automatic t_pre();
    logic [2:0] cs [2] = '{CS_DIV8, CS_DIV64};
    int         f [2] = '{8, 64};
    int         h;
    for (int i = 0; i < 2; i++) begin
      start(MODE_FP_CAPT, 16'h000f, 16'h0005, ACT_NONINV, cs[i]);
      repeat (20 * f[i]) @(posedge clk);
      measure(64 * f[i], h);
      chk("prescaled_duty", 24 * f[i], h);
    end
  endtask

  // Start just below a fixed TOP: direction must turn, then overflow at BOTTOM
  task automatic t_top();
    logic [3:0]  md [3] = '{MODE_PC8, MODE_PC9, MODE_PC10};
    logic [15:0] tp [3] = '{TOP_8BIT, TOP_9BIT, TOP_10BIT};
    for (int i = 0; i < 3; i++) begin
      do_reset();
      apb(1'b1, OFF_CTRL, ctrl(md[i], ACT_OFF, CS_DIV1, 1'b0));
      apb(1'b1, OFF_COUNT, {16'h0, tp[i] - 16'd3});
      repeat (10) @(posedge clk);
      rchk("turn_at_top", OFF_STATUS, 32'h1, 32'h1);
      apb(1'b1, OFF_FLAGS, 32'hf);
      apb(1'b1, OFF_COUNT, 32'h4);
      repeat (10) @(posedge clk);
      rchk("ovf_bottom", OFF_FLAGS, 32'h1, 32'h1);
      rchk("up_again", OFF_STATUS, 32'h0, 32'h1);
    end
  endtask

  // Channel B compare stays 0, so its flag sets at BOTTOM
  task automatic t_flags();
    logic [3:0] md [2] = '{MODE_FP_CAPT, MODE_PC_CAPT};
    for (int i = 0; i < 2; i++) begin
      start(md[i], 16'h000f, 16'h0005, ACT_NONINV, CS_DIV1);
      repeat (40) @(posedge clk);
      apb(1'b1, OFF_FLAGS, 32'hf);
      repeat (40) @(posedge clk);
      rchk("flags_set", OFF_FLAGS, 32'hf);
    end
    apb(1'b1, OFF_CTRL, ctrl(MODE_PC_CAPT, ACT_NONINV, 3'h0, 1'b1));
    apb(1'b1, OFF_FLAGS, 32'hf);
    rchk("flags_clear", OFF_FLAGS, 32'h0);
  endtask

  // Channel B at compare 0 spikes once per period; pin A is left undriven
  task automatic t_chan_b();
    int h;
    start(MODE_FP_CAPT, 16'h000f, 16'h0005, ACT_OFF, CS_DIV1);
    apb(1'b1, OFF_CTRL, ctrl(MODE_FP_CAPT, ACT_OFF, CS_DIV1, 1'b0) | 32'h00001080);
    repeat (40) @(posedge clk);
    measure(64, h, 1'b1);
    chk("duty_b", 32'd4, h);
    chk("drive_en_b", 32'h1, {31'h0, pin_b_oe});
    chk("drive_off_a", 32'h0, {31'h0, pin_a_oe});
  endtask

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    srst       = 1'b1;
    psel       = 1'b0;
    penable    = 1'b0;
    pwrite     = 1'b0;
    paddr      = 8'h00;
    pwdata     = 32'h0;
    fails      = 0;
    num_checks = 0;
    cycles     = 0;
    t_regs();
    t_buffer();
    t_wave();
    t_pre();
    t_top();
    t_flags();
    t_chan_b();
    report_and_stop();
  end
endmodule
`default_nettype wire
